// [hdl/trec_pkg.sv]
// shared constants and state codes of the trigger readout event concentrator
package trec_pkg;
  localparam int NUM_IN = 10;
  localparam int NUM_OUT = 2;
  localparam int DW = 32;
  localparam int EVW = 24;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AF = FIFO_DEPTH / 2;
  localparam int PEND_DEPTH = 16;
  localparam int PIPE_DEPTH = 256;
  localparam int LATENCY_DEF = 64;
  localparam int NSAMP_DEF = 5;
  localparam int NSW = 4;
  localparam int SPY_EVERY_DEF = 16;
  localparam int OUT_PAY = 0;
  localparam int OUT_TP = 1;
  localparam logic [7:0] HDR_MARK = 8'hA5;
  localparam logic [7:0] ERR_MARK = 8'hEE;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_HDR = 3'b010,
    ST_CHAN = 3'b011,
    ST_TP = 3'b100
  } trec_state_t;
endpackage

// [hdl/trec_fifo.sv]
// synchronous fifo with valid/ready on both sides and an almost-full flag
`timescale 1ns/1ps
`default_nettype none
module trec_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int AF = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data,
  output logic almost_full
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || AF > DEPTH)
  begin : g_bad
    $error("trec_fifo: depth must be a power of two and af within depth");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic [AW:0] used;
  logic do_wr;
  logic do_rd;
  // occupancy and handshakes
  assign used = wp_r - rp_r;
  assign wr_ready = (used != DEPTH[AW:0]);
  assign rd_valid = (used != '0);
  assign almost_full = (used >= AF[AW:0]);
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;
  assign rd_data = mem[rp_r[AW-1:0]];
  // storage array
  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[wp_r[AW-1:0]] <= wr_data;
    end
  end
  // pointers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/trec_pipe.sv]
// primitive pipeline memory with derandomizer copy on each level-1 accept
`timescale 1ns/1ps
`default_nettype none
module trec_pipe #(
  parameter int LATENCY = trec_pkg::LATENCY_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [trec_pkg::DW-1:0] tp_sample,
  input wire logic level1_accept,
  input wire logic [trec_pkg::NSW-1:0] nsamp,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [trec_pkg::DW-1:0] rd_data,
  output logic tp_lost
);
  localparam int PAW = $clog2(trec_pkg::PIPE_DEPTH);
  if (LATENCY + 16 > trec_pkg::PIPE_DEPTH)
  begin : g_bad
    $error("trec_pipe: latency too long for pipeline memory");
  end
  logic [trec_pkg::DW-1:0] mem [trec_pkg::PIPE_DEPTH];
  logic [PAW-1:0] wp_r;
  logic [PAW-1:0] cp_r;
  logic [trec_pkg::NSW-1:0] left_r;
  logic tp_lost_r;
  logic [PAW-1:0] start;
  logic sq_valid;
  logic sq_ready;
  logic sq_wready;
  logic [PAW-1:0] sq_addr;
  logic dr_wready;
  logic copying;
  // window start: crossing at accept minus latency, centred on nsamp
  assign start = wp_r - PAW'(LATENCY) - PAW'(nsamp >> 1);
  assign copying = (left_r != '0);
  assign sq_ready = !copying;
  assign tp_lost = tp_lost_r;
  // pipeline memory written every cycle
  always_ff @(posedge clk_sys)
  begin
    mem[wp_r] <= tp_sample;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) wp_r <= '0;
    else wp_r <= wp_r + 1'b1;
  end
  // queue of window start addresses, one per accept
  trec_fifo #(.W(PAW), .DEPTH(4), .AF(4)) u_startq (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_valid(level1_accept),
    .wr_ready(sq_wready),
    .wr_data(start),
    .rd_valid(sq_valid),
    .rd_ready(sq_ready),
    .rd_data(sq_addr),
    .almost_full()
  );
  // copier moves nsamp consecutive samples into the derandomizer
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cp_r <= '0;
      left_r <= '0;
    end
    else if (!copying && sq_valid)
    begin
      cp_r <= sq_addr;
      left_r <= nsamp;
    end
    else if (copying)
    begin
      cp_r <= cp_r + 1'b1;
      left_r <= left_r - 1'b1;
    end
  end
  // sticky loss flag, no stall of the pipeline
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) tp_lost_r <= 1'b0;
    else if ((copying && !dr_wready) || (level1_accept && !sq_wready)) tp_lost_r <= 1'b1;
  end
  trec_fifo #(.W(trec_pkg::DW), .DEPTH(trec_pkg::FIFO_DEPTH), .AF(trec_pkg::FIFO_AF)) u_derand (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_valid(copying),
    .wr_ready(dr_wready),
    .wr_data(mem[cp_r]),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_data),
    .almost_full()
  );
endmodule
`default_nettype wire

// [hdl/trec_top.sv]
// concentrator: input fifos, event builder, output fifos, spy and monitors
// Function
// - keep primitive samples for the latency, copy matching ones on each accept
// - assemble primitives with payload of the same event and forward them
// - each link writes its own input fifo under its own handler
// - builder checks fragments, payload goes to the output fifo chosen by route_sel, primitives to output fifo 1
// - accept and event number queued unless the pending list is full; building runs while queue non-empty
// - every stage pushes at full speed, no backpressure to senders; the builder waits for room in both fifos for the header, then in any it is not dropping on
// - output almost-full sampled once, at the start of each event
// - sampled almost-full drops the event's words on that output; an error word with event number replaces the header on both outputs
// - check repeats per event, normal writing resumes by itself
// - buffering fifos twice the nominal depth
// - word counts and checksums kept on each output stream
// - a sampled fraction of events copied to the crate processor spy port
// - ten identical input channels and two output link channels
// - input to output routing is configurable
// - primitive-collecting module drops the output link, exposes data on spy port
// - regional data pipelined, derandomized on accept, pushed to readout crate
// - programmable count of samples centred on the triggering crossing, default five
`timescale 1ns/1ps
`default_nettype none
module trec_top #(
  parameter int NUM_IN = trec_pkg::NUM_IN,
  parameter int LATENCY = trec_pkg::LATENCY_DEF,
  parameter int SPY_EVERY = trec_pkg::SPY_EVERY_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [NUM_IN-1:0] in_valid,
  input wire logic [NUM_IN-1:0] in_last,
  input wire logic [NUM_IN-1:0][trec_pkg::DW-1:0] in_data,
  input wire logic level1_accept,
  input wire logic [trec_pkg::EVW-1:0] level1_event_id,
  input wire logic [trec_pkg::DW-1:0] tp_sample,
  input wire logic [NUM_IN-1:0] route_sel,
  input wire logic tp_mode,
  input wire logic [trec_pkg::NSW-1:0] nsamp,
  output logic [trec_pkg::NUM_OUT-1:0] link_valid,
  output logic [trec_pkg::NUM_OUT-1:0][trec_pkg::DW-1:0] link_data,
  input wire logic [trec_pkg::NUM_OUT-1:0] link_ready,
  output logic spy_valid,
  output logic [trec_pkg::DW-1:0] spy_data,
  output logic [trec_pkg::NUM_OUT-1:0][31:0] mon_words,
  output logic [trec_pkg::NUM_OUT-1:0][31:0] mon_csum,
  output logic [NUM_IN-1:0] in_overflow,
  output logic pend_overflow,
  output logic tp_lost
);
  localparam int DW = trec_pkg::DW;
  localparam int NO = trec_pkg::NUM_OUT;
  localparam int CW = $clog2(NUM_IN);
  localparam int SW = $clog2(SPY_EVERY + 1);
  if (NUM_IN < 2 || NUM_IN > 16 || SPY_EVERY < 1)
  begin : g_bad
    $error("trec_top: input count or spy ratio out of range");
  end
  trec_pkg::trec_state_t state_r;
  logic [trec_pkg::EVW-1:0] ev_r;
  logic [CW-1:0] ch_r;
  logic [trec_pkg::NSW-1:0] cnt_r;
  logic [NO-1:0] drop_r;
  logic spy_on_r;
  logic [SW-1:0] spy_cnt_r;
  logic [NUM_IN-1:0] in_ovf_r;
  logic pend_ovf_r;
  logic [NO-1:0] link_valid_r;
  logic [NO-1:0][DW-1:0] link_data_r;
  logic spy_valid_r;
  logic [DW-1:0] spy_data_r;
  logic [NO-1:0][31:0] words_r;
  logic [NO-1:0][31:0] csum_r;
  // input fifo side
  logic [NUM_IN-1:0] if_wready;
  logic [NUM_IN-1:0] if_rvalid;
  logic [NUM_IN-1:0] if_rready;
  logic [NUM_IN-1:0][DW:0] if_rdata;
  // pending list
  logic pend_wready;
  logic pend_rvalid;
  logic pend_rready;
  logic [trec_pkg::EVW-1:0] pend_ev;
  // primitive stream
  logic tp_rvalid;
  logic tp_rready;
  logic [DW-1:0] tp_rdata;
  // output fifo side
  logic [NO-1:0] of_wvalid;
  logic [NO-1:0] of_wready;
  logic [NO-1:0] of_afull;
  logic [NO-1:0] of_rvalid;
  logic [NO-1:0] of_rready;
  logic [NO-1:0][DW-1:0] of_rdata;
  logic [DW-1:0] ow_data;
  logic hdr_go;
  logic cur_tgt;
  logic cur_last;
  logic chan_fire;
  logic tp_fire;
  assign link_valid = link_valid_r;
  assign link_data = link_data_r;
  assign spy_valid = spy_valid_r;
  assign spy_data = spy_data_r;
  assign mon_words = words_r;
  assign mon_csum = csum_r;
  assign in_overflow = in_ovf_r;
  assign pend_overflow = pend_ovf_r;
  // per-link input fifo and input handler
  for (genvar i = 0; i < NUM_IN; i++)
  begin : g_in
    trec_fifo #(.W(DW + 1), .DEPTH(trec_pkg::FIFO_DEPTH), .AF(trec_pkg::FIFO_AF)) u_input_fifo (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wr_valid(in_valid[i]),
      .wr_ready(if_wready[i]),
      .wr_data({in_last[i], in_data[i]}),
      .rd_valid(if_rvalid[i]),
      .rd_ready(if_rready[i]),
      .rd_data(if_rdata[i]),
      .almost_full()
    );
    // handler flags words the link pushed into a full fifo
    always_ff @(posedge clk_sys)
    begin
      if (!reset_n) in_ovf_r[i] <= 1'b0;
      else if (in_valid[i] && !if_wready[i]) in_ovf_r[i] <= 1'b1;
    end
  end
  // list of accepted events waiting to be built
  trec_fifo #(.W(trec_pkg::EVW), .DEPTH(trec_pkg::PEND_DEPTH), .AF(trec_pkg::PEND_DEPTH)) u_pend (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_valid(level1_accept),
    .wr_ready(pend_wready),
    .wr_data(level1_event_id),
    .rd_valid(pend_rvalid),
    .rd_ready(pend_rready),
    .rd_data(pend_ev),
    .almost_full()
  );
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) pend_ovf_r <= 1'b0;
    else if (level1_accept && !pend_wready) pend_ovf_r <= 1'b1;
  end
  // primitive pipeline and derandomizer
  trec_pipe #(.LATENCY(LATENCY)) u_pipe (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tp_sample(tp_sample),
    .level1_accept(level1_accept),
    .nsamp(nsamp),
    .rd_valid(tp_rvalid),
    .rd_ready(tp_rready),
    .rd_data(tp_rdata),
    .tp_lost(tp_lost)
  );
  // builder data steering: one word per cycle towards its output
  always_comb
  begin
    of_wvalid = '0;
    if_rready = '0;
    tp_rready = 1'b0;
    pend_rready = 1'b0;
    ow_data = '0;
    hdr_go = &of_wready;
    cur_tgt = route_sel[ch_r];
    cur_last = if_rdata[ch_r][DW];
    chan_fire = 1'b0;
    tp_fire = 1'b0;
    case (state_r)
      trec_pkg::ST_IDLE:
      begin
        pend_rready = 1'b1;
      end
      trec_pkg::ST_HDR:
      begin
        ow_data = {trec_pkg::HDR_MARK, ev_r};
        of_wvalid = {NO{hdr_go}};
        for (int o = 0; o < NO; o++)
        begin
          if (drop_r[o]) ow_data = {trec_pkg::ERR_MARK, ev_r};
        end
      end
      trec_pkg::ST_CHAN:
      begin
        ow_data = if_rdata[ch_r][DW-1:0];
        chan_fire = if_rvalid[ch_r] && (drop_r[cur_tgt] || of_wready[cur_tgt]);
        if_rready[ch_r] = chan_fire;
        of_wvalid[cur_tgt] = chan_fire && !drop_r[cur_tgt];
      end
      trec_pkg::ST_TP:
      begin
        ow_data = tp_rdata;
        tp_fire = tp_rvalid && (drop_r[trec_pkg::OUT_TP] || of_wready[trec_pkg::OUT_TP]);
        tp_rready = tp_fire;
        of_wvalid[trec_pkg::OUT_TP] = tp_fire && !drop_r[trec_pkg::OUT_TP];
      end
      default:
      begin
        ow_data = '0;
      end
    endcase
  end
  // event builder sequencing
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_r <= trec_pkg::ST_IDLE;
      ev_r <= '0;
      ch_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        trec_pkg::ST_IDLE:
        begin
          if (pend_rvalid)
          begin
            ev_r <= pend_ev;
            state_r <= trec_pkg::ST_CHECK;
          end
        end
        trec_pkg::ST_CHECK:
        begin
          state_r <= trec_pkg::ST_HDR;
        end
        trec_pkg::ST_HDR:
        begin
          if (hdr_go)
          begin
            ch_r <= '0;
            state_r <= trec_pkg::ST_CHAN;
          end
        end
        trec_pkg::ST_CHAN:
        begin
          if (chan_fire && cur_last)
          begin
            if (ch_r == CW'(NUM_IN - 1))
            begin
              cnt_r <= '0;
              state_r <= (nsamp == '0) ? trec_pkg::ST_IDLE : trec_pkg::ST_TP;
            end
            else
            begin
              ch_r <= ch_r + 1'b1;
            end
          end
        end
        trec_pkg::ST_TP:
        begin
          if (tp_fire)
          begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == nsamp - 1'b1) state_r <= trec_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state_r <= trec_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // almost-full sampled once per event, never mid-event
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n) drop_r <= '0;
    else if (state_r == trec_pkg::ST_CHECK) drop_r <= of_afull;
  end
  // spy selection: every nth event, or every event when collecting primitives
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      spy_on_r <= 1'b0;
      spy_cnt_r <= '0;
    end
    else if (state_r == trec_pkg::ST_CHECK)
    begin
      spy_on_r <= tp_mode || (spy_cnt_r == '0);
      spy_cnt_r <= (spy_cnt_r == SW'(SPY_EVERY - 1)) ? '0 : spy_cnt_r + 1'b1;
    end
  end
  // spy port mirrors each word the builder stores for a selected event
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      spy_valid_r <= 1'b0;
      spy_data_r <= '0;
    end
    else
    begin
      spy_valid_r <= spy_on_r && (|of_wvalid);
      spy_data_r <= ow_data;
    end
  end
  // output fifos, twice the nominal depth, half-full is almost full
  for (genvar o = 0; o < NO; o++)
  begin : g_out
    trec_fifo #(.W(DW), .DEPTH(trec_pkg::FIFO_DEPTH), .AF(trec_pkg::FIFO_AF)) u_ofifo (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .wr_valid(of_wvalid[o]),
      .wr_ready(of_wready[o]),
      .wr_data(ow_data),
      .rd_valid(of_rvalid[o]),
      .rd_ready(of_rready[o]),
      .rd_data(of_rdata[o]),
      .almost_full(of_afull[o])
    );
    assign of_rready[o] = !link_valid_r[o] || link_ready[o];
    // link output stage; link silenced when the module collects primitives
    always_ff @(posedge clk_sys)
    begin
      if (!reset_n)
      begin
        link_valid_r[o] <= 1'b0;
        link_data_r[o] <= '0;
      end
      else if (of_rready[o])
      begin
        link_valid_r[o] <= of_rvalid[o] && !tp_mode;
        link_data_r[o] <= of_rdata[o];
      end
    end
    // running word count and additive checksum of stored words
    always_ff @(posedge clk_sys)
    begin
      if (!reset_n)
      begin
        words_r[o] <= '0;
        csum_r[o] <= '0;
      end
      else if (of_wvalid[o])
      begin
        words_r[o] <= words_r[o] + 32'h0000_0001;
        csum_r[o] <= csum_r[o] + 32'(ow_data);
      end
    end
  end
endmodule
`default_nettype wire

// [tb/trec_checker_assertions.sv]
// assertion checker on the concentrator top ports, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module trec_checker #(
  parameter int NUM_IN = 10
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [NUM_IN-1:0] in_valid,
  input wire logic level1_accept,
  input wire logic tp_mode,
  input wire logic [trec_pkg::NUM_OUT-1:0] link_valid,
  input wire logic [trec_pkg::NUM_OUT-1:0][trec_pkg::DW-1:0] link_data,
  input wire logic [trec_pkg::NUM_OUT-1:0] link_ready,
  input wire logic [trec_pkg::NUM_OUT-1:0][31:0] mon_words,
  input wire logic [trec_pkg::NUM_OUT-1:0][31:0] mon_csum,
  input wire logic [NUM_IN-1:0] in_overflow,
  input wire logic pend_overflow,
  input wire logic tp_lost
);
  // one clock domain, reset disables every check
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // a stalled output word stays put on each link
  property p_hold0;
    link_valid[0] && !link_ready[0] |=> link_valid[0] && $stable(link_data[0]);
  endproperty
  a_hold0: assert property (p_hold0) else $error("link 0 word changed while stalled");
  property p_hold1;
    link_valid[1] && !link_ready[1] |=> link_valid[1] && $stable(link_data[1]);
  endproperty
  a_hold1: assert property (p_hold1) else $error("link 1 word changed while stalled");

  // primitive-collecting mode keeps both links silent
  property p_tp_quiet;
    tp_mode |-> link_valid == 2'h0;
  endproperty
  a_tp_quiet: assert property (p_tp_quiet) else $error("link active in primitive mode");

  // lost-word flags are sticky and only set by a push
  property p_in_sticky;
    (in_overflow & $past(in_overflow)) == $past(in_overflow);
  endproperty
  a_in_sticky: assert property (p_in_sticky) else $error("input overflow flag cleared");
  property p_in_cause;
    ((in_overflow & ~$past(in_overflow)) & ~$past(in_valid)) == '0;
  endproperty
  a_in_cause: assert property (p_in_cause) else $error("input overflow without a push");

  // pending list overflow needs an accept and then holds
  property p_pend_sticky;
    pend_overflow |=> pend_overflow;
  endproperty
  a_pend_sticky: assert property (p_pend_sticky) else $error("pending overflow flag cleared");
  property p_pend_cause;
    $rose(pend_overflow) |-> $past(level1_accept);
  endproperty
  a_pend_cause: assert property (p_pend_cause) else $error("pending overflow without accept");

  // lost primitive flag holds until reset
  property p_lost_sticky;
    tp_lost |=> tp_lost;
  endproperty
  a_lost_sticky: assert property (p_lost_sticky) else $error("primitive lost flag cleared");

  // word counters step by at most one and the sums move only with them
  property p_words_step;
    (mon_words[0] - $past(mon_words[0])) <= 32'h1 && (mon_words[1] - $past(mon_words[1])) <= 32'h1;
  endproperty
  a_words_step: assert property (p_words_step) else $error("word count jumped");
  property p_csum_tie;
    (!$stable(mon_words[0]) || $stable(mon_csum[0])) && (!$stable(mon_words[1]) || $stable(mon_csum[1]));
  endproperty
  a_csum_tie: assert property (p_csum_tie) else $error("checksum moved without a word");
endmodule

bind trec_top trec_checker #(.NUM_IN(NUM_IN)) chk_u (.clk_sys(clk_sys), .reset_n(reset_n),
  .in_valid(in_valid), .level1_accept(level1_accept), .tp_mode(tp_mode), .link_valid(link_valid),
  .link_data(link_data), .link_ready(link_ready), .mon_words(mon_words), .mon_csum(mon_csum),
  .in_overflow(in_overflow), .pend_overflow(pend_overflow), .tp_lost(tp_lost));
`default_nettype wire

// [tb/trec_link_model.sv]
// readout boards pushing one-word fragments and the downstream link sink
`timescale 1ns/1ps
`default_nettype none
module trec_link_model (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [23:0] send_id,
  input wire logic flood,
  input wire logic [1:0] stall_mode,
  output logic [trec_pkg::NUM_IN-1:0] in_valid,
  output logic [trec_pkg::NUM_IN-1:0] in_last,
  output logic [trec_pkg::NUM_IN-1:0][31:0] in_data,
  output logic [1:0] link_ready
);
  int seed = 76;

  // quiet lines before the first falling edge
  initial
  begin
    in_valid = '0;
    in_last = '0;
    in_data = '0;
    link_ready = 2'h0;
  end

  // boards push at once, never waiting; idle lines carry noise
  always @(negedge clk_sys)
  begin
    for (int i = 0; i < trec_pkg::NUM_IN; i++)
    begin
      in_valid[i] <= send || (flood && i == trec_pkg::NUM_IN - 1);
      in_last[i] <= send ? 1'b1 : (flood ? 1'b0 : 1'($random(seed)));
      in_data[i] <= send ? {8'(i), send_id} : 32'($random(seed));
    end
    case (stall_mode)
      2'h0: link_ready <= 2'h3;
      2'h1: link_ready <= 2'($random(seed));
      default: link_ready <= 2'h2;
    endcase
  end
endmodule
`default_nettype wire

// [tb/tb_trigger_readout_event_concentrator.sv]
// self-checking bench of the concentrator with boards and link model
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_readout_event_concentrator;
  localparam int NI = trec_pkg::NUM_IN;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [NI-1:0] in_valid;
  logic [NI-1:0] in_last;
  logic [NI-1:0][31:0] in_data;
  logic [NI-1:0] route_sel = '0;
  logic [NI-1:0] in_overflow;
  logic level1_accept = 1'b0;
  logic tp_mode = 1'b0;
  logic send = 1'b0;
  logic flood = 1'b0;
  logic pend_overflow;
  logic tp_lost;
  logic spy_valid;
  logic [1:0] stall_mode = 2'h0;
  logic [3:0] nsamp = 4'h5;
  logic [23:0] level1_event_id = 24'h0;
  logic [31:0] tp_sample = 32'h0;
  logic [31:0] spy_data;
  logic [31:0] spy_first;
  logic [1:0] link_valid;
  logic [1:0] link_ready;
  logic [1:0][31:0] link_data;
  logic [1:0][31:0] mon_words;
  logic [1:0][31:0] mon_csum;
  logic [33:0] exp_q [2][$];
  logic [31:0] last_samp [2];
  logic [31:0] got_sum [2] = '{32'h0, 32'h0};
  int got_n [2] = '{0, 0};
  int spy_n = 0;
  int err_count = 0;
  int checked = 0;
  int seed = 76;

  trec_top #(.LATENCY(8), .SPY_EVERY(2)) dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .in_valid(in_valid),
    .in_last(in_last), .in_data(in_data), .level1_accept(level1_accept), .level1_event_id(level1_event_id),
    .tp_sample(tp_sample), .route_sel(route_sel), .tp_mode(tp_mode), .nsamp(nsamp), .link_valid(link_valid),
    .link_data(link_data), .link_ready(link_ready), .spy_valid(spy_valid), .spy_data(spy_data),
    .mon_words(mon_words), .mon_csum(mon_csum), .in_overflow(in_overflow), .pend_overflow(pend_overflow),
    .tp_lost(tp_lost));
  trec_link_model model_u (.clk_sys(clk_sys), .send(send), .send_id(level1_event_id), .flood(flood),
    .stall_mode(stall_mode), .in_valid(in_valid), .in_last(in_last), .in_data(in_data), .link_ready(link_ready));

  // clock and a running primitive sample
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys)
    tp_sample <= tp_sample + 32'h1;

  function automatic logic [31:0] hdr(logic [7:0] mark, logic [23:0] id);
    return {mark, id};
  endfunction
  function automatic logic [31:0] frag(int i, logic [23:0] id);
    return {8'(i), id};
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
    checked++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one accept with its fragments; queues what each link must carry
  task automatic fire(logic [23:0] id, logic [3:0] ns, logic drop0);
    logic [7:0] mark;
    mark = drop0 ? trec_pkg::ERR_MARK : trec_pkg::HDR_MARK;
    @(negedge clk_sys);
    nsamp <= ns;
    level1_event_id <= id;
    level1_accept <= 1'b1;
    send <= 1'b1;
    exp_q[0].push_back({2'b00, hdr(mark, id)});
    exp_q[1].push_back({2'b00, hdr(mark, id)});
    for (int i = 0; i < NI; i++)
      if (!(drop0 && !route_sel[i]))
        exp_q[route_sel[i]].push_back({2'b00, frag(i, id)});
    for (int s = 0; s < ns; s++)
      exp_q[1].push_back({s == 0, 1'b1, 32'h0});
  endtask

  task automatic calm();
    @(negedge clk_sys);
    level1_accept <= 1'b0;
    send <= 1'b0;
  endtask

  task automatic drain();
    int n = 0;
    while ((exp_q[0].size() > 0 || exp_q[1].size() > 0) && n < 2000)
    begin
      tick(1);
      n++;
    end
    if (n == 2000)
    begin
      $display("mismatch drain expected 0 seen %0d", exp_q[0].size() + exp_q[1].size());
      err_count++;
    end
    tick(4);
  endtask

  // scoreboard of both output links and the spy port
  always @(posedge clk_sys)
  begin
    for (int k = 0; k < 2; k++)
      if (reset_n && link_valid[k] && link_ready[k])
      begin
        got_n[k]++;
        got_sum[k] += link_data[k];
        if (exp_q[k].size() == 0)
        begin
          $display("mismatch link word expected none seen %h", link_data[k]);
          err_count++;
        end
        else
        begin
          if (!exp_q[k][0][32])
            check("link word", exp_q[k][0][31:0], link_data[k]);
          else if (!exp_q[k][0][33])
            check("primitive sample", last_samp[k] + 32'h1, link_data[k]);
          last_samp[k] = link_data[k];
          void'(exp_q[k].pop_front());
        end
      end
    if (spy_valid)
    begin
      if (spy_n == 0)
        spy_first <= spy_data;
      spy_n++;
    end
  end

  // watchdog
  initial
  begin
    #200000;
    err_count++;
    stop_test();
  end

  // main sequence
  initial
  begin
    tick(5);
    reset_n <= 1'b1;
    route_sel <= 10'h0F0;
    tick(20); // pipeline memory must hold a full latency of samples before the first accept
    fire(24'h000001, 4'h5, 1'b0);
    calm();
    drain();
    check("spy header", hdr(trec_pkg::HDR_MARK, 24'h000001), spy_first);
    spy_n = 0;
    fire(24'h000002, 4'h5, 1'b0);
    calm();
    drain();
    check("spy count", 32'h0, 32'(spy_n));
    stall_mode <= 2'h1;
    for (int e = 0; e < 12; e++)
    begin
      route_sel <= 10'($random(seed));
      fire(24'($random(seed)), 4'($unsigned($random(seed)) % 8), 1'b0);
      calm();
      drain();
    end
    stall_mode <= 2'h0;
    route_sel <= 10'h3FF;
    fire(24'hFFFFFF, 4'hF, 1'b0);
    fire(24'h000000, 4'hF, 1'b0);
    calm();
    drain();
    route_sel <= 10'h000;
    stall_mode <= 2'h2;
    fire(24'h0000A1, 4'h3, 1'b0);
    calm();
    tick(60);
    fire(24'h0000A2, 4'h3, 1'b1);
    calm();
    tick(60);
    stall_mode <= 2'h0;
    drain();
    fire(24'h0000A3, 4'h3, 1'b0);
    calm();
    drain();
    for (int k = 0; k < 2; k++)
    begin
      check("word count", 32'(got_n[k]), mon_words[k]);
      check("checksum", got_sum[k], mon_csum[k]);
    end
    check("primitive lost", 32'h0, 32'(tp_lost));
    tp_mode <= 1'b1;
    spy_n = 0;
    fire(24'h0000B0, 4'h5, 1'b0);
    calm();
    exp_q[0].delete();
    exp_q[1].delete();
    tick(80);
    check("primitive spy header", hdr(trec_pkg::HDR_MARK, 24'h0000B0), spy_first);
    tp_mode <= 1'b0;
    flood <= 1'b1;
    tick(20);
    flood <= 1'b0;
    tick(2);
    check("input overflow", 32'h200, 32'(in_overflow));
    exp_q[0].push_back({2'b00, hdr(trec_pkg::HDR_MARK, 24'h0000C0)});
    exp_q[1].push_back({2'b00, hdr(trec_pkg::HDR_MARK, 24'h0000C0)});
    level1_event_id <= 24'h0000C0;
    level1_accept <= 1'b1;
    tick(20);
    level1_accept <= 1'b0;
    drain();
    check("pending overflow", 32'h1, 32'(pend_overflow));
    check("primitive lost", 32'h1, 32'(tp_lost));
    stop_test();
  end
endmodule
`default_nettype wire
